// ==== dv/dac_partner.sv ====
// Behavioural DAC and comparator at the far side of the sample port
`timescale 1ns/1ps
`default_nettype none
module dac_partner (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Sample port
  input wire logic [dds_pkg::AMP_W-1:0] data_i,
  input wire logic valid_i,
  output logic ready_o,
  // Comparator
  input wire logic comp_en_i,
  output logic comp_o,
  // Bench control
  input wire logic stall_i,
  output var int hold_errors_o
);
  logic [dds_pkg::AMP_W-1:0] held;
  logic waiting;

  // Ready follows the bench's stall request
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= !stall_i;
    end
  end

  // A stalled sample must stay put until taken
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      waiting <= 1'b0;
      held <= '0;
      hold_errors_o <= 0;
    end else begin
      waiting <= valid_i & !ready_o;
      held <= data_i;
      if (waiting && data_i !== held) begin
        hold_errors_o <= hold_errors_o + 1;
      end
    end
  end

  // Zero-crossing detector; toggles when disabled so no stale level shows
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      comp_o <= 1'b0;
    end else begin
      comp_o <= comp_en_i ? data_i[dds_pkg::AMP_W-1] : ~comp_o;
    end
  end
endmodule
`default_nettype wire

// ==== dv/dds_phase_to_sine_core_tb_top.sv ====
// Self-checking bench for the phase-to-sine core
`timescale 1ns/1ps
`default_nettype none
module dds_phase_to_sine_core_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fpin = 1'b0;
  logic ppin = 1'b0;
  logic dreset = 1'b0;
  logic stall = 1'b0;
  logic comp, sign, sign_oe, comp_en, dac_valid, dac_ready;
  logic [9:0] dac_data;
  logic [9:0] s;
  logic [31:0] rdv, r;
  logic rerr;
  logic [11:0] oa, ob;
  int hold_errors;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [11:0] p1, p2;
  int tctl [5] = '{0, 1, 4, 4, 5};
  int tpin [5] = '{0, 0, 1, 0, 0};
  int tstep [5] = '{1, -1, -1, 1, 1};

  initial begin
    forever #2.5 clk = ~clk;
  end

  dds_core dut (
    .MCLK_I(clk), .RST_N_I(rst_n),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .FREQ_SELECT_PIN_I(fpin), .PHASE_SELECT_PIN_I(ppin), .DDS_RESET_I(dreset),
    .COMP_I(comp), .SIGN_O(sign), .SIGN_OE_O(sign_oe), .COMP_EN_O(comp_en),
    .DAC_DATA_O(dac_data), .DAC_VALID_O(dac_valid), .DAC_READY_I(dac_ready)
  );

  dac_partner dac (
    .clk_i(clk), .rst_n_i(rst_n), .data_i(dac_data), .valid_i(dac_valid),
    .ready_o(dac_ready), .comp_en_i(comp_en), .comp_o(comp), .stall_i(stall),
    .hold_errors_o(hold_errors)
  );

  task automatic give_verdict();
    if (num_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; answer taken at the edge where pready is high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdv = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ph(output logic [11:0] p);
    apb(1'b0, dds_pkg::STATUS_OFS, 32'h0);
    p = rdv[11:0];
  endtask

  task automatic wait_cy(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic pulse();
    dreset <= 1'b1;
    wait_cy(5);
    dreset <= 1'b0;
    wait_cy(20);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(32'h9e21));
    wait_cy(10);
    rst_n <= 1'b1;
    wait_cy(4);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check(rdv, 32'h0);
    end
    apb(1'b0, 8'h20, 32'h0);
    check(rdv, 32'h0);
    check(32'(rerr), 32'h1);
    oa = 12'($urandom);
    ob = 12'($urandom);
    r = $urandom;
    apb(1'b1, dds_pkg::FREQ_B_OFS, r);
    apb(1'b0, dds_pkg::FREQ_B_OFS, 32'h0);
    check(rdv, r & 32'h0fffffff);
    apb(1'b1, dds_pkg::PHASE_A_OFS, {20'hfffff, oa});
    apb(1'b0, dds_pkg::PHASE_A_OFS, 32'h0);
    check(rdv, {20'h0, oa});
    apb(1'b1, dds_pkg::PHASE_B_OFS, {20'h0, ob});
    // Steps of the phase between reads three cycles apart
    apb(1'b1, dds_pkg::FREQ_A_OFS, 32'h0010000);
    apb(1'b1, dds_pkg::FREQ_B_OFS, 32'h0fff0000);
    for (int i = 0; i < 5; i++) begin
      fpin <= tpin[i][0];
      apb(1'b1, dds_pkg::CONTROL_OFS, 32'(tctl[i]));
      wait_cy(20);
      ph(p1);
      ph(p2);
      check(32'((p2 - p1) & 'hfff), 32'((3 * tstep[i]) & 'hfff));
    end
    fpin <= 1'b0;
    apb(1'b1, dds_pkg::FREQ_A_OFS, 32'h0);
    apb(1'b1, dds_pkg::CONTROL_OFS, 32'h0);
    dreset <= 1'b1;
    wait_cy(20);
    ph(p1);
    check(32'(p1), 32'h0);
    check(32'(rdv[24]), 32'h1);
    check(32'(dac_data), 32'(dds_pkg::AMP_MID));
    dreset <= 1'b0;
    wait_cy(20);
    apb(1'b0, dds_pkg::FREQ_B_OFS, 32'h0);
    check(rdv, 32'h0fff0000);
    for (int i = 0; i < 4; i++) begin
      ppin <= i[0];
      apb(1'b1, dds_pkg::CONTROL_OFS, i[1] ? 32'h4 : {30'h0, i[0], 1'b0});
      wait_cy(20);
      ph(p1);
      check(32'(p1), {20'h0, i[0] ? ob : oa});
    end
    ppin <= 1'b0;
    apb(1'b1, dds_pkg::CONTROL_OFS, 32'h1);
    wait_cy(50);
    apb(1'b1, dds_pkg::CONTROL_OFS, 32'h0);
    wait_cy(20);
    ph(p1);
    ph(p2);
    check(32'(p2), 32'(p1));
    check(32'(p1 != oa), 32'h1);
    apb(1'b1, dds_pkg::PHASE_A_OFS, {20'h0, oa + 12'hc00});
    wait_cy(20);
    ph(p2);
    check(32'(p2), 32'((p1 + 'hc00) & 'hfff));
    // Select pin to DAC latency
    apb(1'b1, dds_pkg::PHASE_A_OFS, 32'h0);
    apb(1'b1, dds_pkg::FREQ_B_OFS, 32'h4000000);
    apb(1'b1, dds_pkg::CONTROL_OFS, 32'h4);
    pulse();
    check(32'(dac_data), 32'(dds_pkg::AMP_MID));
    fpin <= 1'b1;
    wait_cy(7);
    #1 check(32'(dac_data), 32'(dds_pkg::AMP_MID));
    @(posedge clk);
    #1 check(32'(dac_data !== dds_pkg::AMP_MID), 32'h1);
    // Sign pin, comparator and waveform selection
    fpin <= 1'b0;
    apb(1'b1, dds_pkg::PHASE_A_OFS, 32'h955);
    pulse();
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, dds_pkg::CONTROL_OFS, {26'h0, i[1], i[0], 4'h4});
      wait_cy(5);
      check(32'(comp_en), 32'(i[0] & i[1]));
      check(32'(sign_oe), 32'(i[0]));
      check(32'(sign), 32'(i[0] & (i[1] ? comp : 1'b1)));
    end
    apb(1'b1, dds_pkg::CONTROL_OFS, 32'h4);
    wait_cy(20);
    s = dac_data;
    check(32'(s < dds_pkg::AMP_MID), 32'h1);
    apb(1'b1, dds_pkg::CONTROL_OFS, 32'h1c);
    wait_cy(20);
    check(32'(dac_data), 32'(s));
    apb(1'b1, dds_pkg::CONTROL_OFS, 32'hc);
    wait_cy(20);
    check(32'(dac_data !== s), 32'h1);
    // Backpressure fills the FIFO and stalls the accumulator
    apb(1'b1, dds_pkg::FREQ_A_OFS, 32'h0010000);
    apb(1'b1, dds_pkg::CONTROL_OFS, 32'h0);
    stall <= 1'b1;
    wait_cy(40);
    ph(p1);
    check(32'(rdv[20:16]), 32'(dds_pkg::FIFO_DEPTH));
    check(32'(dac_valid), 32'h1);
    ph(p2);
    check(32'(p2), 32'(p1));
    stall <= 1'b0;
    wait_cy(40);
    ph(p1);
    ph(p2);
    check(32'((p2 - p1) & 'hfff), 32'h3);
    check(32'(hold_errors), 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire

// ==== inc/dds_pkg.sv ====
// Shared constants and types for the phase-to-sine core
package dds_pkg;

  localparam int ACC_W = 28;
  localparam int PHASE_W = 12;
  localparam int AMP_W = 10;
  localparam int FIFO_DEPTH = 16;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] FREQ_A_OFS = 8'h00;
  localparam logic [7:0] FREQ_B_OFS = 8'h04;
  localparam logic [7:0] PHASE_A_OFS = 8'h08;
  localparam logic [7:0] PHASE_B_OFS = 8'h0c;
  localparam logic [7:0] CONTROL_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;

  // Control register field positions
  localparam int CTL_FREQ_SEL_BIT = 0;
  localparam int CTL_PHASE_SEL_BIT = 1;
  localparam int CTL_PIN_SEL_BIT = 2;
  localparam int CTL_MODE_BIT = 3;
  localparam int CTL_LOE_BIT = 4;
  localparam int CTL_SIGN_SRC_BIT = 5;

  // Status register field positions
  localparam int STS_PHASE_LSB = 0;
  localparam int STS_LEVEL_LSB = 16;
  localparam int STS_DDS_RST_BIT = 24;

  // Reset values of the software registers
  localparam logic [ACC_W-1:0] FREQ_RST = 28'h0000000;
  localparam logic [PHASE_W-1:0] PHASE_RST = 12'h000;
  localparam logic [5:0] CONTROL_RST = 6'h00;

  // Midscale amplitude code
  localparam logic [AMP_W-1:0] AMP_MID = 10'h200;
  localparam logic [AMP_W-2:0] AMP_HALF = 9'h1ff;

  typedef struct packed {
    logic sign_pin_source_select;
    logic logic_output_enable;
    logic mode;
    logic pin_control;
    logic phase_select_bit;
    logic freq_select_bit;
  } ctrl_t;

  typedef struct packed {
    logic [ACC_W-1:0] frequency_word_a;
    logic [ACC_W-1:0] frequency_word_b;
    logic [PHASE_W-1:0] phase_offset_a;
    logic [PHASE_W-1:0] phase_offset_b;
  } tuning_t;

endpackage

// ==== rtl/dds_core.sv ====
// Phase accumulator, phase modulator, sine table and output routing
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dds_core (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [dds_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Device pins
  input wire logic FREQ_SELECT_PIN_I,
  input wire logic PHASE_SELECT_PIN_I,
  input wire logic DDS_RESET_I,
  input wire logic COMP_I,
  output logic SIGN_O,
  output logic SIGN_OE_O,
  output logic COMP_EN_O,
  // DAC sample port
  output logic [dds_pkg::AMP_W-1:0] DAC_DATA_O,
  output logic DAC_VALID_O,
  input wire logic DAC_READY_I
);
  localparam int AW = dds_pkg::ACC_W;
  localparam int PW = dds_pkg::PHASE_W;
  localparam int MW = dds_pkg::AMP_W;

  // Bhaskara-style sine estimate, midscale at phase zero
  function automatic logic [MW-1:0] sine_code(input logic [PW-1:0] addr);
    longint n;
    longint num;
    longint den;
    longint amp;
    n = longint'(addr[PW-2:0]);
    num = 16 * n * (2048 - n);
    den = 5 * 2048 * 2048 - 4 * n * (2048 - n);
    amp = (longint'(dds_pkg::AMP_HALF) * num) / den;
    if (addr[PW-1]) begin
      sine_code = MW'(longint'(dds_pkg::AMP_MID) - amp);
    end else begin
      sine_code = MW'(longint'(dds_pkg::AMP_MID) + amp);
    end
  endfunction

  logic [MW-1:0] sine_rom [2**PW];
  initial begin
    for (int i = 0; i < 2**PW; i++) begin
      sine_rom[i] = sine_code(PW'(i));
    end
  end

  logic [1:0] rst_sync_reg;
  logic rst_n;
  dds_pkg::ctrl_t ctrl_reg;
  dds_pkg::tuning_t tune_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic freq_sel_reg;
  logic phase_sel_reg;
  logic phase_sel_dly_reg;
  logic dds_rst_reg;
  logic [AW-1:0] acc_reg;
  logic [PW-1:0] offset_reg;
  logic [PW-1:0] mod_phase_reg;
  logic [MW-1:0] lut_reg;
  logic msb_reg;
  logic [MW-1:0] shape_reg;
  logic [MW-1:0] hold_reg;
  logic pipe_valid_reg;
  logic sign_reg;
  logic sign_oe_reg;
  logic comp_en_reg;
  logic [MW-1:0] dac_data_reg;
  logic dac_valid_reg;
  logic adv;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [MW-1:0] fifo_out_data;
  logic [$clog2(dds_pkg::FIFO_DEPTH):0] fifo_level;
  logic setup;
  logic wr_en;
  logic [AW-1:0] word_next;

  assign rst_n = rst_sync_reg[1];

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // APB: answer in the access cycle, no wait states
  assign setup = PSEL_I && !PENABLE_I;
  assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && pready_reg;

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= 1'b0;
      if (setup) begin
        prdata_reg <= 32'h0;
        case (PADDR_I)
          dds_pkg::FREQ_A_OFS: prdata_reg <= 32'(tune_reg.frequency_word_a);
          dds_pkg::FREQ_B_OFS: prdata_reg <= 32'(tune_reg.frequency_word_b);
          dds_pkg::PHASE_A_OFS: prdata_reg <= 32'(tune_reg.phase_offset_a);
          dds_pkg::PHASE_B_OFS: prdata_reg <= 32'(tune_reg.phase_offset_b);
          dds_pkg::CONTROL_OFS: prdata_reg <= 32'(ctrl_reg);
          dds_pkg::STATUS_OFS: begin
            prdata_reg[dds_pkg::STS_PHASE_LSB +: PW] <= mod_phase_reg;
            prdata_reg[dds_pkg::STS_LEVEL_LSB +: 5] <= fifo_level;
            prdata_reg[dds_pkg::STS_DDS_RST_BIT] <= dds_rst_reg;
          end
          default: pslverr_reg <= 1'b1;
        endcase
      end
    end
  end

  // Software registers: untouched by the datapath reset
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      tune_reg <= {dds_pkg::FREQ_RST, dds_pkg::FREQ_RST, dds_pkg::PHASE_RST, dds_pkg::PHASE_RST};
      ctrl_reg <= dds_pkg::CONTROL_RST;
    end else if (wr_en) begin
      case (PADDR_I)
        dds_pkg::FREQ_A_OFS: tune_reg.frequency_word_a <= PWDATA_I[AW-1:0];
        dds_pkg::FREQ_B_OFS: tune_reg.frequency_word_b <= PWDATA_I[AW-1:0];
        dds_pkg::PHASE_A_OFS: tune_reg.phase_offset_a <= PWDATA_I[PW-1:0];
        dds_pkg::PHASE_B_OFS: tune_reg.phase_offset_b <= PWDATA_I[PW-1:0];
        dds_pkg::CONTROL_OFS: ctrl_reg <= PWDATA_I[5:0];
        default: ;
      endcase
    end
  end

  // Select sampling; phase select delayed one cycle more than the frequency select before it reaches offset_reg
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      freq_sel_reg <= 1'b0;
      phase_sel_reg <= 1'b0;
      phase_sel_dly_reg <= 1'b0;
      dds_rst_reg <= 1'b0;
    end else if (adv) begin
      freq_sel_reg <= ctrl_reg.pin_control ? FREQ_SELECT_PIN_I : ctrl_reg.freq_select_bit;
      phase_sel_reg <= ctrl_reg.pin_control ? PHASE_SELECT_PIN_I
                                            : ctrl_reg.phase_select_bit;
      phase_sel_dly_reg <= phase_sel_reg;
      dds_rst_reg <= DDS_RESET_I;
    end
  end

  assign word_next = freq_sel_reg ? tune_reg.frequency_word_b : tune_reg.frequency_word_a;

  // Accumulator, modulator and table, one stage per clock
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= '0;
      offset_reg <= '0;
      mod_phase_reg <= '0;
      lut_reg <= dds_pkg::AMP_MID;
      msb_reg <= 1'b0;
    end else if (adv) begin
      if (dds_rst_reg) begin
        acc_reg <= '0;
        offset_reg <= '0;
        mod_phase_reg <= '0;
      end else begin
        acc_reg <= acc_reg + word_next;
        offset_reg <= phase_sel_dly_reg ? tune_reg.phase_offset_b : tune_reg.phase_offset_a;
        mod_phase_reg <= acc_reg[AW-1 -: PW] + offset_reg;
      end
      lut_reg <= sine_rom[mod_phase_reg];
      msb_reg <= mod_phase_reg[PW-1];
    end
  end

  // Waveform choice, then a balancing stage before the FIFO
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      shape_reg <= dds_pkg::AMP_MID;
      hold_reg <= dds_pkg::AMP_MID;
      pipe_valid_reg <= 1'b0;
    end else if (adv) begin
      if (ctrl_reg.mode && !ctrl_reg.logic_output_enable) begin
        shape_reg <= msb_reg ? ~mod_phase_reg[PW-2 -: MW] : mod_phase_reg[PW-2 -: MW];
      end else begin
        shape_reg <= lut_reg;
      end
      hold_reg <= shape_reg;
      pipe_valid_reg <= 1'b1;
    end
  end

  // Sign pin and comparator enable
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      sign_reg <= 1'b0;
      sign_oe_reg <= 1'b0;
      comp_en_reg <= 1'b0;
    end else begin
      comp_en_reg <= ctrl_reg.sign_pin_source_select && ctrl_reg.logic_output_enable;
      sign_oe_reg <= ctrl_reg.logic_output_enable;
      sign_reg <= ctrl_reg.logic_output_enable &&
                  (ctrl_reg.sign_pin_source_select ? COMP_I : msb_reg);
    end
  end

  sample_fifo #(
    .WIDTH(MW),
    .DEPTH(dds_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(MCLK_I),
    .rst_n_i(rst_n),
    .in_valid_i(pipe_valid_reg),
    .in_ready_o(adv),
    .in_data_i(hold_reg),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data),
    .level_o(fifo_level)
  );

  assign fifo_pop = fifo_out_valid && (!dac_valid_reg || DAC_READY_I);

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      dac_data_reg <= dds_pkg::AMP_MID;
      dac_valid_reg <= 1'b0;
    end else if (!dac_valid_reg || DAC_READY_I) begin
      dac_valid_reg <= fifo_out_valid;
      if (fifo_out_valid) begin
        dac_data_reg <= fifo_out_data;
      end
    end
  end

  assign PRDATA_O = prdata_reg;
  assign PREADY_O = pready_reg;
  assign PSLVERR_O = pslverr_reg;
  assign SIGN_O = sign_reg;
  assign SIGN_OE_O = sign_oe_reg;
  assign COMP_EN_O = comp_en_reg;
  assign DAC_DATA_O = dac_data_reg;
  assign DAC_VALID_O = dac_valid_reg;

  // Checks
  property p_acc_step;
    @(posedge MCLK_I) disable iff (!rst_n)
    adv && !dds_rst_reg |=> acc_reg == $past(acc_reg) + $past(word_next);
  endproperty
  a_acc_step: assert property (p_acc_step) else $error("accumulator step wrong");

  property p_dds_reset;
    @(posedge MCLK_I) disable iff (!rst_n)
    adv && dds_rst_reg |=> acc_reg == '0 ##1 (!$past(adv) || lut_reg == dds_pkg::AMP_MID);
  endproperty
  a_dds_reset: assert property (p_dds_reset) else $error("datapath reset not midscale");

  property p_regs_kept;
    @(posedge MCLK_I) disable iff (!rst_n)
    dds_rst_reg && !wr_en |=> $stable(tune_reg) && $stable(ctrl_reg);
  endproperty
  a_regs_kept: assert property (p_regs_kept) else $error("registers changed by reset");

  property p_phase_add;
    @(posedge MCLK_I) disable iff (!rst_n)
    adv && !dds_rst_reg |=> mod_phase_reg == PW'($past(acc_reg[AW-1 -: PW]) + $past(offset_reg));
  endproperty
  a_phase_add: assert property (p_phase_add) else $error("phase offset sum wrong");

  property p_freq_pick;
    @(posedge MCLK_I) disable iff (!rst_n)
    adv && ctrl_reg.pin_control && $stable(ctrl_reg) |=> freq_sel_reg == $past(FREQ_SELECT_PIN_I);
  endproperty
  a_freq_pick: assert property (p_freq_pick) else $error("frequency select not followed");

  property p_phase_pick;
    @(posedge MCLK_I) disable iff (!rst_n)
    $past(adv) && $past(adv, 2) && !$past(ctrl_reg.pin_control, 2) |->
      phase_sel_dly_reg == $past(ctrl_reg.phase_select_bit, 2);
  endproperty
  a_phase_pick: assert property (p_phase_pick) else $error("phase select not followed");

  property p_comp_en;
    @(posedge MCLK_I) disable iff (!rst_n)
    ##1 COMP_EN_O == ($past(ctrl_reg.sign_pin_source_select) && $past(ctrl_reg.logic_output_enable));
  endproperty
  a_comp_en: assert property (p_comp_en) else $error("comparator enable wrong");

  property p_sign_off;
    @(posedge MCLK_I) disable iff (!rst_n)
    !ctrl_reg.logic_output_enable |=> !SIGN_OE_O && !SIGN_O;
  endproperty
  a_sign_off: assert property (p_sign_off) else $error("sign pin driven while disabled");

  property p_lut;
    @(posedge MCLK_I) disable iff (!rst_n)
    adv |=> lut_reg == sine_rom[$past(mod_phase_reg)];
  endproperty
  a_lut: assert property (p_lut) else $error("sine table output wrong");

  property p_apb_ready;
    @(posedge MCLK_I) disable iff (!rst_n)
    setup |=> PREADY_O ##1 !PREADY_O;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("APB ready timing wrong");

  c_freq_switch: cover property (@(posedge MCLK_I) disable iff (!rst_n) $changed(freq_sel_reg));
  c_fifo_full: cover property (@(posedge MCLK_I) disable iff (!rst_n) !adv);
  c_comp_path: cover property (@(posedge MCLK_I) disable iff (!rst_n) COMP_EN_O && SIGN_OE_O);
endmodule
`default_nettype wire

// ==== rtl/sample_fifo.sv ====
// Synchronous FIFO between the waveform pipeline and the DAC port
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // Fill level
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_o = (count_reg != (PTR_W+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem[rd_ptr_reg];
  assign level_o = count_reg;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (PTR_W+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (PTR_W+1)'(1);
      end
    end
  end
endmodule
`default_nettype wire
